//--- ddc_pkg.sv
// Shared constants and types for the dual DAC digital control block
package ddc_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int DDC_SHIFT_BITS = 24;
  localparam int DDC_CMD_MSB = 23;
  localparam int DDC_CMD_LSB = 20;
  localparam int DDC_MASK_A_POS = 16;
  localparam int DDC_MASK_B_POS = 17;
  localparam int DDC_DATA_MSB = 15;
  localparam int DDC_REF_OFF_POS = 0;
  localparam int DDC_BYTES_PER_WORD = 3;
  localparam int DDC_BYTE_BITS = 8;

  // ----------------------------------------------------------------
  // Slave address: upper five bits are fixed inside the part
  // ----------------------------------------------------------------
  localparam logic [4:0] DDC_ADDR_UPPER = 5'h0C;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [3:0] DDC_CMD_WRITE_IN = 4'h1;
  localparam logic [3:0] DDC_CMD_UPDATE = 4'h2;
  localparam logic [3:0] DDC_CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] DDC_CMD_REF_SETUP = 4'h7;

  // ----------------------------------------------------------------
  // Reset values and synchroniser width
  // ----------------------------------------------------------------
  localparam logic DDC_REF_EN_RESET = 1'b1;
  localparam int DDC_SYNC_BITS = 8;

  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    DDC_ST_IDLE = 7'h01,
    DDC_ST_ADDR = 7'h02,
    DDC_ST_ADDR_ACK = 7'h04,
    DDC_ST_RX = 7'h08,
    DDC_ST_RX_ACK = 7'h10,
    DDC_ST_TX = 7'h20,
    DDC_ST_TX_ACK = 7'h40
  } ddc_state_type;

endpackage

//--- ddc_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module ddc_sync
  import ddc_pkg::*;
#(
  parameter int WIDTH = DDC_SYNC_BITS
)
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } ddc_sync_state_type;

  ddc_sync_state_type s_reg;
  ddc_sync_state_type s_next;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("ddc_sync: WIDTH must be at least 1");
    end
  endgenerate

  // The first stage feeds only the second stage
  always_comb
  begin
    s_next.meta = i_async;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign o_sync = s_reg.stable;

endmodule

//--- ddc_buf.sv
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ns
module ddc_buf
  import ddc_pkg::*;
#(
  parameter int WIDTH = DDC_SHIFT_BITS
)
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
  } ddc_buf_state_type;

  ddc_buf_state_type s_reg;
  ddc_buf_state_type s_next;
  logic push;
  logic pop;

  generate
    if (WIDTH < 1)
    begin : g_chk
      $error("ddc_buf: WIDTH must be at least 1");
    end
  endgenerate

  assign o_ready = (s_reg.count != 2'h2);
  assign o_valid = (s_reg.count != 2'h0);
  assign o_data = s_reg.mem[s_reg.rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    s_next = s_reg;
    if (push)
    begin
      s_next.mem[s_reg.wr_ptr] = i_data;
      s_next.wr_ptr = ~s_reg.wr_ptr;
    end
    if (pop)
    begin
      s_next.rd_ptr = ~s_reg.rd_ptr;
    end
    case ({push, pop})
      2'b10: s_next.count = s_reg.count + 2'h1;
      2'b01: s_next.count = s_reg.count - 2'h1;
      default: s_next.count = s_reg.count;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule

//--- ddc_top.sv
// Dual DAC digital control: serial slave, input and DAC registers, load and reset pins
//
// Summary of operation
// - Serial words arrive on open-drain data/clock lines into a 24-bit shift word.
// - Address select low pin sets slave address bit 0.
// - Address select high pin sets slave address bit 1.
// - Load strobe low copies pending input registers to DAC registers together.
// - Load strobe works asynchronously (edge) or synchronously (held low at write).
// - Reset pin acts on its falling edge, independent of the serial clock.
// - While reset pin is low, load strobe pulses are ignored.
// - Reset edge loads input and DAC registers with zero or midscale per select.
// - Power-up value is zero scale if select low, midscale if high.
// - Power-up initialisation waits until the reset pin is released.
// - Gain pin picks span of reference or twice reference for both channels.
// - After power-up the reference pin is an output with internal reference on.
`timescale 1ns/1ns
module ddc_top
  import ddc_pkg::*;
#(
  parameter int DAC_BITS = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire logic i_address_select_low,
  input wire logic i_address_select_high,
  input wire logic i_load_dac_strobe_n,
  input wire logic i_reset_n,
  input wire logic i_reset_value_select,
  input wire logic i_gain,
  output logic [DAC_BITS-1:0] o_channel_a_output,
  output logic [DAC_BITS-1:0] o_channel_b_output,
  output logic o_gain_double,
  output logic o_ref_out_en,
  output logic o_init_done
);

  // ----------------------------------------------------------------
  // Types, helpers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    ddc_state_type state;
    logic sda_oe;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [DDC_SHIFT_BITS-1:0] word;
    logic rw;
    logic rd_sel_b;
    logic push_valid;
    logic scl_d;
    logic sda_d;
    logic strobe_d;
    logic rst_d;
    logic [DAC_BITS-1:0] in_a;
    logic [DAC_BITS-1:0] in_b;
    logic [DAC_BITS-1:0] dac_a;
    logic [DAC_BITS-1:0] dac_b;
    logic [1:0] pend;
    logic ref_en;
    logic gain;
    logic init_done;
  } ddc_top_state_type;

  ddc_top_state_type s_reg;
  ddc_top_state_type s_next;

  logic [DDC_SYNC_BITS-1:0] pins;
  logic scl;
  logic sda;
  logic adr_lo;
  logic adr_hi;
  logic strobe_n;
  logic rst_n;
  logic dflt_sel;
  logic gain;
  logic buf_ready;
  logic buf_valid;
  logic [DDC_SHIFT_BITS-1:0] buf_data;
  logic drain;

  generate
    if (DAC_BITS < 1 || DAC_BITS > 16)
    begin : g_chk
      $error("ddc_top: DAC_BITS must be 1 to 16");
    end
  endgenerate

  function automatic logic [DAC_BITS-1:0] ddc_default(input logic sel);
    logic [DAC_BITS-1:0] v;
    v = '0;
    if (sel)
    begin
      v[DAC_BITS-1] = 1'b1;
    end
    return v;
  endfunction

  function automatic logic [7:0] ddc_tx_byte(input logic [DAC_BITS-1:0] code, input logic lo);
    logic [15:0] w;
    w = '0;
    w[15 -: DAC_BITS] = code;
    return lo ? w[7:0] : w[15:8];
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and word buffer
  // ----------------------------------------------------------------
  ddc_sync #(.WIDTH(DDC_SYNC_BITS)) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_async({i_scl, i_sda, i_address_select_low, i_address_select_high,
              i_load_dac_strobe_n, i_reset_n, i_reset_value_select, i_gain}),
    .o_sync(pins)
  );

  assign {scl, sda, adr_lo, adr_hi, strobe_n, rst_n, dflt_sel, gain} = pins;

  // A held reset pin stalls the drain so up to two words wait in the buffer; a further word is not acknowledged
  assign drain = s_reg.init_done && rst_n && s_reg.rst_d;

  ddc_buf #(.WIDTH(DDC_SHIFT_BITS)) u_buf (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_valid(s_reg.push_valid),
    .o_ready(buf_ready),
    .i_data(s_reg.word),
    .o_valid(buf_valid),
    .i_ready(drain),
    .o_data(buf_data)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [6:0] my_addr;
    logic [3:0] cmd;
    logic [DAC_BITS-1:0] data;
    logic [1:0] mask;
    logic [7:0] tb;
    scl_rise = scl && !s_reg.scl_d;
    scl_fall = !scl && s_reg.scl_d;
    start = scl && s_reg.scl_d && s_reg.sda_d && !sda;
    stop = scl && s_reg.scl_d && !s_reg.sda_d && sda;
    my_addr = {DDC_ADDR_UPPER, adr_hi, adr_lo};
    cmd = buf_data[DDC_CMD_MSB:DDC_CMD_LSB];
    data = buf_data[DDC_DATA_MSB -: DAC_BITS];
    mask = {buf_data[DDC_MASK_B_POS], buf_data[DDC_MASK_A_POS]};
    tb = '0;
    s_next = s_reg;
    s_next.scl_d = scl;
    s_next.sda_d = sda;
    s_next.strobe_d = strobe_n;
    s_next.rst_d = rst_n;
    s_next.gain = gain;
    s_next.push_valid = 1'b0;

    // Serial slave; bits taken on clock rise, data line changed on clock fall
    if (start)
    begin
      s_next.state = DDC_ST_ADDR;
      s_next.bit_cnt = '0;
      s_next.sda_oe = 1'b0;
    end
    else if (stop)
    begin
      s_next.state = DDC_ST_IDLE;
      s_next.sda_oe = 1'b0;
    end
    else
    begin
      case (s_reg.state)
        DDC_ST_ADDR, DDC_ST_RX:
        begin
          if (scl_rise)
          begin
            s_next.shift = {s_reg.shift[6:0], sda};
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && s_reg.bit_cnt == 4'(DDC_BYTE_BITS))
          begin
            if (s_reg.state == DDC_ST_ADDR)
            begin
              if (s_reg.shift[7:1] == my_addr)
              begin
                s_next.state = DDC_ST_ADDR_ACK;
                s_next.sda_oe = 1'b1;
                s_next.rw = s_reg.shift[0];
                s_next.byte_cnt = '0;
              end
              else
              begin
                s_next.state = DDC_ST_IDLE;
              end
            end
            else
            begin
              s_next.word = {s_reg.word[DDC_SHIFT_BITS-9:0], s_reg.shift};
              if (s_reg.byte_cnt != 2'(DDC_BYTES_PER_WORD - 1))
              begin
                s_next.byte_cnt = s_reg.byte_cnt + 2'h1;
                s_next.sda_oe = 1'b1;
                s_next.state = DDC_ST_RX_ACK;
              end
              else if (buf_ready)
              begin
                // Full word accepted only when the buffer has room
                s_next.byte_cnt = '0;
                s_next.push_valid = 1'b1;
                s_next.sda_oe = 1'b1;
                s_next.state = DDC_ST_RX_ACK;
              end
              else
              begin
                s_next.state = DDC_ST_IDLE;
              end
            end
          end
        end
        DDC_ST_ADDR_ACK, DDC_ST_RX_ACK:
        begin
          if (scl_fall)
          begin
            s_next.bit_cnt = '0;
            if (s_reg.state == DDC_ST_ADDR_ACK && s_reg.rw)
            begin
              tb = ddc_tx_byte(s_reg.rd_sel_b ? s_reg.dac_b : s_reg.dac_a, 1'b0);
              s_next.shift = tb;
              s_next.sda_oe = ~tb[7];
              s_next.state = DDC_ST_TX;
            end
            else
            begin
              s_next.sda_oe = 1'b0;
              s_next.state = DDC_ST_RX;
            end
          end
        end
        DDC_ST_TX:
        begin
          if (scl_rise)
          begin
            s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (s_reg.bit_cnt == 4'(DDC_BYTE_BITS))
            begin
              s_next.sda_oe = 1'b0;
              s_next.state = DDC_ST_TX_ACK;
              s_next.byte_cnt = {1'b0, ~s_reg.byte_cnt[0]};
            end
            else
            begin
              s_next.shift = {s_reg.shift[6:0], 1'b0};
              s_next.sda_oe = ~s_reg.shift[6];
            end
          end
        end
        DDC_ST_TX_ACK:
        begin
          if (scl_rise && sda)
          begin
            s_next.state = DDC_ST_IDLE;
          end
          else if (scl_fall)
          begin
            tb = ddc_tx_byte(s_reg.rd_sel_b ? s_reg.dac_b : s_reg.dac_a, s_reg.byte_cnt[0]);
            s_next.shift = tb;
            s_next.sda_oe = ~tb[7];
            s_next.bit_cnt = '0;
            s_next.state = DDC_ST_TX;
          end
        end
        default:
        begin
          s_next.state = DDC_ST_IDLE;
          s_next.sda_oe = 1'b0;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Channel registers
    // ----------------------------------------------------------------
    if (!s_reg.init_done)
    begin
      if (rst_n)
      begin
        s_next.in_a = ddc_default(dflt_sel);
        s_next.in_b = ddc_default(dflt_sel);
        s_next.dac_a = ddc_default(dflt_sel);
        s_next.dac_b = ddc_default(dflt_sel);
        s_next.init_done = 1'b1;
      end
    end
    else if (s_reg.rst_d && !rst_n)
    begin
      // Falling edge of the reset pin overrides everything else
      s_next.in_a = ddc_default(dflt_sel);
      s_next.in_b = ddc_default(dflt_sel);
      s_next.dac_a = ddc_default(dflt_sel);
      s_next.dac_b = ddc_default(dflt_sel);
      s_next.pend = '0;
    end
    else if (rst_n && s_reg.rst_d)
    begin
      // Asynchronous style: strobe falling edge moves pending data
      if (s_reg.strobe_d && !strobe_n)
      begin
        if (s_reg.pend[0])
        begin
          s_next.dac_a = s_reg.in_a;
        end
        if (s_reg.pend[1])
        begin
          s_next.dac_b = s_reg.in_b;
        end
        s_next.pend = '0;
      end
      // A write in the same cycle as the transfer sees the strobe low, so it goes straight to the DAC register and is not lost
      if (buf_valid)
      begin
        s_next.rd_sel_b = mask[1] && !mask[0];
        case (cmd)
          DDC_CMD_WRITE_IN, DDC_CMD_WRITE_UPD:
          begin
            if (mask[0])
            begin
              s_next.in_a = data;
            end
            if (mask[1])
            begin
              s_next.in_b = data;
            end
            // Synchronous style: strobe held low updates at write; also covers tie-low
            if (cmd == DDC_CMD_WRITE_UPD || !strobe_n)
            begin
              if (mask[0])
              begin
                s_next.dac_a = data;
              end
              if (mask[1])
              begin
                s_next.dac_b = data;
              end
              s_next.pend = s_next.pend & ~mask;
            end
            else
            begin
              s_next.pend = s_next.pend | mask;
            end
          end
          DDC_CMD_UPDATE:
          begin
            if (mask[0])
            begin
              s_next.dac_a = s_reg.in_a;
            end
            if (mask[1])
            begin
              s_next.dac_b = s_reg.in_b;
            end
            s_next.pend = s_next.pend & ~mask;
          end
          DDC_CMD_REF_SETUP:
          begin
            s_next.ref_en = ~buf_data[DDC_REF_OFF_POS];
          end
          default:
          begin
            s_next.pend = s_next.pend;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_reg <= '0;
      s_reg.state <= DDC_ST_IDLE;
      s_reg.ref_en <= DDC_REF_EN_RESET;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The clock line is never stretched, so it is only ever received
  assign o_scl_out = 1'b0;
  assign o_scl_oe = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_sda_oe = s_reg.sda_oe;
  assign o_channel_a_output = s_reg.dac_a;
  assign o_channel_b_output = s_reg.dac_b;
  assign o_gain_double = s_reg.gain;
  assign o_ref_out_en = s_reg.ref_en;
  assign o_init_done = s_reg.init_done;

endmodule

//--- ddc_top_sva.sv
// Assertions on the ports of the dual DAC control block
`timescale 1ns/1ns
module ddc_top_sva
  import ddc_pkg::*;
#(
  parameter int DAC_BITS = 16
)
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire logic i_reset_n,
  input wire logic i_reset_value_select,
  input wire logic i_gain,
  input wire logic [DAC_BITS-1:0] o_channel_a_output,
  input wire logic [DAC_BITS-1:0] o_channel_b_output,
  input wire logic o_gain_double,
  input wire logic o_ref_out_en,
  input wire logic o_init_done
);
  logic [DAC_BITS-1:0] dflt;
  // Midscale is the top bit alone
  always_comb
  begin
    dflt = '0;
    dflt[DAC_BITS-1] = i_reset_value_select;
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_sys_rst);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_lines;
    !o_scl_out && !o_scl_oe && !o_sda_out;
  endproperty
  a_lines: assert property (p_lines) else $error("line driven high");
  property p_oe_clk_low;
    $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved, clock high");
  property p_gain;
    $changed(i_gain) ##1 $stable(i_gain) [*4] |-> o_gain_double == i_gain;
  endproperty
  a_gain: assert property (p_gain) else $error("gain not followed");
  property p_rst_load;
    $fell(i_reset_n) ##1 !i_reset_n [*6] |-> o_channel_a_output == dflt && o_channel_b_output == dflt;
  endproperty
  a_rst_load: assert property (p_rst_load) else $error("reset code not loaded");
  property p_hold_in_rst;
    !i_reset_n [*8] |-> $stable(o_channel_a_output) && $stable(o_channel_b_output);
  endproperty
  a_hold_in_rst: assert property (p_hold_in_rst) else $error("output moved in reset");
  property p_init_wait;
    !i_reset_n && !o_init_done |=> !o_init_done;
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("init before release");
  property p_init_done;
    i_reset_n [*8] |-> o_init_done;
  endproperty
  a_init_done: assert property (p_init_done) else $error("init late");
  property p_ref_on;
    $fell(i_sys_rst) |-> o_ref_out_en;
  endproperty
  a_ref_on: assert property (p_ref_on) else $error("reference off at start");
endmodule

bind ddc_top ddc_top_sva #(.DAC_BITS(DAC_BITS)) u_ddc_top_sva (
  .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl), .o_scl_out(o_scl_out),
  .o_scl_oe(o_scl_oe),
  .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe), .i_reset_n(i_reset_n),
  .i_reset_value_select(i_reset_value_select), .i_gain(i_gain),
  .o_channel_a_output(o_channel_a_output), .o_channel_b_output(o_channel_b_output),
  .o_gain_double(o_gain_double), .o_ref_out_en(o_ref_out_en), .o_init_done(o_init_done)
);

//--- ddc_i2c_master.sv
// Two-wire bus master model on the far side of the device
`timescale 1ns/1ns
module ddc_i2c_master
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  // Released lines float high through the pull-ups
  initial
  begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
  end
  // ------------------------------------------------------------
  // Bit timing: 20 system clocks make one 80 ns link period
  // ------------------------------------------------------------
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Data moves well after the clock falls, so it never races the clock edge
  task automatic bit_io(input logic b, output logic q);
    wait_clk(3);
    o_sda_low = ~b;
    wait_clk(7);
    o_scl_low = 1'b0;
    wait_clk(10);
    q = i_sda;
    o_scl_low = 1'b1;
  endtask
  task automatic byte_io(input logic [7:0] b, input logic ack_in, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], q[i]);
    bit_io(ack_in, nak);
  endtask
  task automatic start();
    o_sda_low = 1'b1;
    wait_clk(10);
    o_scl_low = 1'b1;
  endtask
  task automatic stop();
    wait_clk(3);
    o_sda_low = 1'b1;
    wait_clk(7);
    o_scl_low = 1'b0;
    wait_clk(10);
    o_sda_low = 1'b0;
    wait_clk(10);
  endtask
  task automatic xfer(input logic [6:0] adr, input logic [23:0] w, output logic [3:0] naks);
    logic [7:0] q;
    start();
    byte_io({adr, 1'b0}, 1'b1, q, naks[3]);
    for (int i = 2; i >= 0; i--)
      byte_io(w[i*8 +: 8], 1'b1, q, naks[i]);
    stop();
  endtask
  task automatic read16(input logic [6:0] adr, output logic [15:0] d);
    logic n;
    start();
    byte_io({adr, 1'b1}, 1'b1, d[15:8], n);
    byte_io(8'hFF, 1'b0, d[15:8], n);
    byte_io(8'hFF, 1'b1, d[7:0], n);
    stop();
  endtask
endmodule

//--- ddc_top_bench.sv
// Self-checking testbench for the dual DAC control block
`timescale 1ns/1ns
module ddc_top_bench;
  import ddc_pkg::*;
  logic i_sys_clk, i_sys_rst, addr_lo, addr_hi, strobe_n, pin_rst_n, val_sel, gain;
  logic scl_oe, sda_oe, gain_dbl, ref_en, init_done, m_scl_low, m_sda_low;
  logic [15:0] ch_a, ch_b, rd;
  logic [3:0] naks;
  logic [6:0] my_addr;
  wire scl_line, sda_line;
  int mismatches, cmp_count;
  assign scl_line = ~(m_scl_low | scl_oe);
  assign sda_line = ~(m_sda_low | sda_oe);
  assign my_addr = {DDC_ADDR_UPPER, addr_hi, addr_lo};
  ddc_top u_ddc_top (
    .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_scl(scl_line), .o_scl_out(), .o_scl_oe(scl_oe),
    .i_sda(sda_line), .o_sda_out(), .o_sda_oe(sda_oe), .i_address_select_low(addr_lo),
    .i_address_select_high(addr_hi), .i_load_dac_strobe_n(strobe_n), .i_reset_n(pin_rst_n),
    .i_reset_value_select(val_sel), .i_gain(gain), .o_channel_a_output(ch_a),
    .o_channel_b_output(ch_b), .o_gain_double(gain_dbl), .o_ref_out_en(ref_en), .o_init_done(init_done)
  );
  ddc_i2c_master u_ddc_i2c_master (
    .i_clk(i_sys_clk), .i_sda(sda_line), .o_scl_low(m_scl_low), .o_sda_low(m_sda_low)
  );
  initial
  begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk_code(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic send(input logic [6:0] adr, input logic [23:0] w, input logic [3:0] exp_naks);
    u_ddc_i2c_master.xfer(adr, w, naks);
    chk_code("acks", {12'h000, exp_naks}, {12'h000, naks});
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // A full run is near 20000 clocks; the limit leaves a wide margin
  initial
  begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    i_sys_rst = 1'b1;
    {addr_hi, addr_lo} = 2'h0;
    strobe_n = 1'b1;
    pin_rst_n = 1'b0;
    val_sel = 1'b1;
    gain = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    tick(20);
    i_sys_rst = 1'b0;
    tick(20);
    chk_flag("init held", 1'b0, init_done);
    chk_flag("ref out", 1'b1, ref_en);
    pin_rst_n = 1'b1;
    tick(10);
    chk_flag("init", 1'b1, init_done);
    chk_code("a power-up", 16'h8000, ch_a);
    chk_code("b power-up", 16'h8000, ch_b);
    $display("test power_up done");
    for (int p = 0; p < 4; p++)
    begin
      {addr_hi, addr_lo} = p[1:0];
      tick(4);
      send(my_addr ^ 7'h01, 24'h300000, 4'hF);
      send(my_addr ^ 7'h02, 24'h300000, 4'hF);
      send(my_addr ^ 7'h40, 24'h300000, 4'hF);
      send(my_addr, {DDC_CMD_WRITE_UPD, 4'h3, 14'h1234, p[1:0]}, 4'h0);
      tick(8);
      chk_code("a written", {14'h1234, p[1:0]}, ch_a);
    end
    $display("test address done");
    send(my_addr, {DDC_CMD_WRITE_IN, 4'h1, 16'hA5A5}, 4'h0);
    send(my_addr, {DDC_CMD_WRITE_IN, 4'h2, 16'h5A5A}, 4'h0);
    tick(8);
    chk_code("a pending", 16'h48D3, ch_a);
    strobe_n = 1'b0;
    for (int n = 0; n < 12 && ch_a !== 16'hA5A5; n++)
      tick(1);
    chk_code("a strobed", 16'hA5A5, ch_a);
    chk_code("b with a", 16'h5A5A, ch_b);
    // Strobe now stays low, as a board that ties it would
    send(my_addr, {DDC_CMD_WRITE_IN, 4'h1, 16'h0F0F}, 4'h0);
    tick(8);
    chk_code("a tied low", 16'h0F0F, ch_a);
    chk_code("b kept", 16'h5A5A, ch_b);
    strobe_n = 1'b1;
    $display("test strobe done");
    val_sel = 1'b0;
    tick(4);
    pin_rst_n = 1'b0;
    tick(8);
    chk_code("a reset", 16'h0000, ch_a);
    chk_code("b reset", 16'h0000, ch_b);
    send(my_addr, {DDC_CMD_WRITE_UPD, 4'h3, 16'h1111}, 4'h0);
    send(my_addr, {DDC_CMD_WRITE_UPD, 4'h3, 16'h2222}, 4'h0);
    send(my_addr, {DDC_CMD_WRITE_UPD, 4'h3, 16'h3333}, 4'h1);
    strobe_n = 1'b0;
    tick(4);
    strobe_n = 1'b1;
    tick(8);
    chk_code("a in reset", 16'h0000, ch_a);
    pin_rst_n = 1'b1;
    tick(20);
    chk_code("a drained", 16'h2222, ch_a);
    chk_code("b drained", 16'h2222, ch_b);
    $display("test reset_buffer done");
    gain = 1'b1;
    tick(6);
    chk_flag("gain high", 1'b1, gain_dbl);
    gain = 1'b0;
    tick(6);
    chk_flag("gain low", 1'b0, gain_dbl);
    send(my_addr, {DDC_CMD_REF_SETUP, 4'h0, 16'h0001}, 4'h0);
    tick(8);
    chk_flag("ref off", 1'b0, ref_en);
    send(my_addr, {DDC_CMD_REF_SETUP, 4'h0, 16'h0000}, 4'h0);
    tick(8);
    chk_flag("ref on", 1'b1, ref_en);
    u_ddc_i2c_master.read16(my_addr, rd);
    chk_code("read a", 16'h2222, rd);
    $display("test gain_ref_read done");
    end_sim();
  end
endmodule
